// ===== common/mwg_cfg.svh
// mwg_cfg.svh: limits, reset values and timing counts of the modulation generator
// assumes inclusion by bare name; definitions only
`ifndef MWG_CFG_SVH
`define MWG_CFG_SVH
// clock and undivided point clock rates
`define MWG_CLK_HZ        10000000
`define MWG_PCLK_AM_HZ    5000000
`define MWG_PCLK_FM_HZ    1250000
`define MWG_BASE_DIV_AM   (`MWG_CLK_HZ / `MWG_PCLK_AM_HZ)
`define MWG_BASE_DIV_FM   (`MWG_CLK_HZ / `MWG_PCLK_FM_HZ)
// prescaler constant k in Hz, frequencies held in mHz
`define MWG_K_AM_HZ       4900
`define MWG_K_FM_HZ       624
`define MWG_MHZ_PER_HZ    1000
`define MWG_S_MAX         (1 << 20)
`define MWG_S_RST         1
`define MWG_FMIN_MHZ      10
`define MWG_FMAX_AM_MHZ   20000000
`define MWG_FMAX_FM_MHZ   10000000
// table length limits and source table
`define MWG_P_MIN         2048
`define MWG_P_MAX         4096
`define MWG_SRC_LEN       4096
`define MWG_STEP_FRAC     16
// carrier band width for burst limits
`define MWG_BAND_HZ       1000000
`define MWG_BAND_TOP      4
`endif

// ===== common/mwg_pkg.sv
// mwg_pkg: types of the modulation waveform generator
// assumes mwg_cfg.svh supplies all numeric constants
package mwg_pkg;
  typedef enum logic {MWG_AM = 1'b0, MWG_FM = 1'b1} mwg_mod_t;
  typedef enum logic [1:0] {
    MWG_SQUARE = 2'h0, MWG_RAMP = 2'h1, MWG_TRIANGLE = 2'h2, MWG_ARB = 2'h3
  } mwg_shape_t;
  // gray codes along the recompute path
  typedef enum logic [2:0] {
    MWG_IDLE = 3'h0, MWG_DIV_S = 3'h1, MWG_DIV_P = 3'h3, MWG_DIV_STEP = 3'h2,
    MWG_FILL_A = 3'h6, MWG_FILL_B = 3'h7, MWG_FILL_W = 3'h5
  } mwg_state_t;
  typedef struct packed {
    mwg_mod_t   mod_type;
    mwg_shape_t shape;
    logic [24:0] mod_freq_mhz;
    logic [23:0] carrier_hz;
    logic        carrier_limited;
    logic [15:0] burst_count;
    logic [15:0] burst_rate;
    logic [11:0] burst_phase;
  } mwg_param_t;
  typedef struct packed {
    logic [7:0]  am_code;
    logic [11:0] fm_word;
  } mwg_sample_t;
endpackage : mwg_pkg

// ===== rtl/mwg_divider.sv
// mwg_divider: sequential restoring divider, one quotient bit per clock
// assumes operands stay stable from start until done
`timescale 1ns/1ps
module mwg_divider #(
  parameter int W = 48
) (
  // clock and reset
  input  wire logic         ref_clk,
  input  wire logic         rst_n,
  // request
  input  wire logic         start,
  input  wire logic [W-1:0] num,
  input  wire logic [W-1:0] den,
  // answer
  output logic              busy,
  output logic              done,
  output logic [W-1:0]      quo
);
  logic [W-1:0] rem_ff;
  logic [W-1:0] q_ff;
  logic [6:0]   cnt_ff;
  logic [W:0]   trial;

  // shift in next dividend bit and try the subtraction
  assign trial = {rem_ff, q_ff[W-1]} - {1'b0, den};

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      rem_ff <= '0;
      q_ff   <= '0;
      cnt_ff <= 7'h00;
      busy   <= 1'b0;
      done   <= 1'b0;
    end else begin
      done <= 1'b0;
      if (start && !busy) begin
        rem_ff <= '0;
        q_ff   <= num;
        cnt_ff <= 7'(W);
        busy   <= 1'b1;
      end else if (busy) begin
        if (trial[W]) begin
          rem_ff <= {rem_ff[W-2:0], q_ff[W-1]};
          q_ff   <= {q_ff[W-2:0], 1'b0};
        end else begin
          rem_ff <= trial[W-1:0];
          q_ff   <= {q_ff[W-2:0], 1'b1};
        end
        cnt_ff <= cnt_ff - 7'h01;
        if (cnt_ff == 7'h01) begin
          busy <= 1'b0;
          done <= 1'b1;
        end
      end
    end
  end

  assign quo = q_ff;
endmodule : mwg_divider

// ===== rtl/mwg_gen.sv
// mwg_gen: low-speed modulation waveform generator with its own table RAM
// assumes arb_rd_data is valid in the cycle after arb_rd_addr changes
// Summary of operation
// - burst count, rate, phase or carrier change recomputes and reloads the table
// - burst count floor is 1 to 1 MHz, one more per MHz, 5 near 5 MHz
// - table length always between 2048 and 4096 points
// - arbitrary shapes are interpolated linearly, built-in shapes decimated
// - samples are read at a variable point clock set with the prescaler
// - every shape keeps being sampled at high modulation frequencies
// - change of type, shape or frequency recomputes and reloads the table
// - table RAM is separate; the arbitrary source is only read
// - amplitude modulation gets 8-bit signed samples, peak plus or minus 127
// - frequency modulation gets samples with 12-bit frequency resolution
// - undivided point clock is 5 MSa/s for AM, 1.25 MSa/s for FM
// - prescaler takes integers 1 to 2 to the 20
// - prescaler is k over frequency, truncated, at least one
// - points are 2C over (1+S)F, rounded down to even
// - frequency range 10 mHz to 20 kHz for AM, 10 kHz for FM
// - selected shape is resized to exactly the computed length and stored
// - diagnostic query returns prescaler then point count
// - triggered burst runs in step with carrier and halts after the count
`timescale 1ns/1ps
`include "mwg_cfg.svh"
module mwg_gen
  import mwg_pkg::*;
(
  // clock and reset
  input  wire logic        ref_clk,
  input  wire logic        rst_n,
  // parameter set
  input  mwg_param_t       param,
  // arbitrary source table, read only
  output logic [11:0]      arb_rd_addr,
  input  wire logic [11:0] arb_rd_data,
  // burst control
  input  wire logic        burst_en,
  input  wire logic        burst_trig,
  output logic             carrier_gate,
  output logic [15:0]      burst_count_applied,
  // sample stream
  output mwg_sample_t      smp,
  output logic             smp_valid,
  input  wire logic        smp_ready,
  // diagnostic memory query
  input  wire logic        diagnostic_memory_query,
  output logic             diag_valid,
  output logic             diag_last,
  output logic [31:0]      diag_data,
  // status
  output logic             busy,
  output logic             range_err
);
  localparam logic [47:0] NUM_S_AM = 48'(`MWG_K_AM_HZ * `MWG_MHZ_PER_HZ);
  localparam logic [47:0] NUM_S_FM = 48'(`MWG_K_FM_HZ * `MWG_MHZ_PER_HZ);
  localparam logic [47:0] NUM_P_AM = 48'(64'(2 * `MWG_PCLK_AM_HZ) * `MWG_MHZ_PER_HZ);
  localparam logic [47:0] NUM_P_FM = 48'(64'(2 * `MWG_PCLK_FM_HZ) * `MWG_MHZ_PER_HZ);
  localparam logic [47:0] NUM_STEP = 48'(64'(`MWG_SRC_LEN) << `MWG_STEP_FRAC);
  localparam logic [47:0] S_MAX    = 48'(`MWG_S_MAX);
  localparam logic [12:0] P_MIN    = 13'(`MWG_P_MIN);
  localparam logic [12:0] P_MAX    = 13'(`MWG_P_MAX);

  mwg_state_t   state_ff, nxt_state;
  mwg_param_t   cur_ff, nxt_cur;
  logic [11:0]  mod_ram [`MWG_P_MAX];
  logic [20:0]  s_ff;
  logic [12:0]  p_ff;
  logic [27:0]  step_ff;
  logic [27:0]  pos_ff;
  logic [12:0]  wr_idx_ff;
  logic [11:0]  a_ff;
  logic [11:0]  arb_addr_ff;
  logic         tbl_ok_ff;
  logic         launch_ff;
  logic         range_err_ff;
  logic         busy_ff;
  logic         chg;
  logic         in_div;
  logic         div_start, div_busy, div_done;
  logic [47:0]  div_num, div_den, div_quo;
  logic [24:0]  fmax, fcl;
  logic [47:0]  p_even;
  logic [11:0]  ram_wdata, shape_val;
  logic [12:0]  diff;
  logic [20:0]  interp_prod;
  logic         ram_we;

  // a difference in any field counts, so unrelated edits also rebuild
  assign chg    = (state_ff == MWG_IDLE) && (nxt_cur != cur_ff);
  assign in_div = (state_ff == MWG_DIV_S) || (state_ff == MWG_DIV_P) ||
                  (state_ff == MWG_DIV_STEP);

  // frequency clamped into the supported range of the selected type
  always_comb begin
    fmax = (param.mod_type == MWG_AM) ? 25'(`MWG_FMAX_AM_MHZ) : 25'(`MWG_FMAX_FM_MHZ);
    fcl  = param.mod_freq_mhz;
    if (fcl < 25'(`MWG_FMIN_MHZ)) begin
      fcl = 25'(`MWG_FMIN_MHZ);
    end else if (fcl > fmax) begin
      fcl = fmax;
    end
    nxt_cur              = param;
    nxt_cur.mod_freq_mhz = fcl;
  end

  // recompute sequence: prescaler, length, resize step, then table fill
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      MWG_IDLE:     if (chg) nxt_state = MWG_DIV_S;
      MWG_DIV_S:    if (div_done) nxt_state = MWG_DIV_P;
      MWG_DIV_P:    if (div_done) nxt_state = MWG_DIV_STEP;
      MWG_DIV_STEP: if (div_done) nxt_state = MWG_FILL_A;
      MWG_FILL_A:   nxt_state = MWG_FILL_B;
      MWG_FILL_B:   nxt_state = MWG_FILL_W;
      MWG_FILL_W:   nxt_state = (wr_idx_ff == p_ff - 13'h0001) ? MWG_IDLE : MWG_FILL_A;
      default:      nxt_state = MWG_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      state_ff <= MWG_IDLE;
      busy_ff  <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      busy_ff  <= (nxt_state != MWG_IDLE);
    end
  end

  // capture the parameter set on a change; a change mid-fill waits for idle
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      cur_ff       <= '0;
      range_err_ff <= 1'b0;
    end else if (chg) begin
      cur_ff       <= nxt_cur;
      range_err_ff <= (nxt_cur.mod_freq_mhz != param.mod_freq_mhz);
    end
  end

  // divider operands per phase of the sequence
  always_comb begin
    div_num = NUM_STEP;
    div_den = 48'(p_ff);
    if (state_ff == MWG_DIV_S) begin
      div_num = (cur_ff.mod_type == MWG_AM) ? NUM_S_AM : NUM_S_FM;
      div_den = 48'(cur_ff.mod_freq_mhz);
    end else if (state_ff == MWG_DIV_P) begin
      div_num = (cur_ff.mod_type == MWG_AM) ? NUM_P_AM : NUM_P_FM;
      div_den = 48'((25'(s_ff) + 25'h0000001) * 48'(cur_ff.mod_freq_mhz));
    end
  end

  assign div_start = in_div && !launch_ff && !div_busy;

  // one launch per divide phase
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      launch_ff <= 1'b0;
    end else if (div_start) begin
      launch_ff <= 1'b1;
    end else if (div_done) begin
      launch_ff <= 1'b0;
    end
  end

  mwg_divider #(.W(48)) u_div (
    .ref_clk (ref_clk),
    .rst_n   (rst_n),
    .start   (div_start),
    .num     (div_num),
    .den     (div_den),
    .busy    (div_busy),
    .done    (div_done),
    .quo     (div_quo)
  );

  assign p_even = {div_quo[47:1], 1'b0};

  // results: prescaler clamped to 1..2^20, length even and inside table limits
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      s_ff    <= 21'(`MWG_S_RST);
      p_ff    <= P_MIN;
      step_ff <= 28'h0000000;
    end else if (div_done) begin
      if (state_ff == MWG_DIV_S) begin
        if (div_quo == 48'h0) begin
          s_ff <= 21'h000001;
        end else if (div_quo > S_MAX) begin
          s_ff <= 21'(S_MAX);
        end else begin
          s_ff <= div_quo[20:0];
        end
      end else if (state_ff == MWG_DIV_P) begin
        if (p_even < 48'(P_MIN)) begin
          p_ff <= P_MIN;
        end else if (p_even > 48'(P_MAX)) begin
          p_ff <= P_MAX;
        end else begin
          p_ff <= p_even[12:0];
        end
      end else begin
        step_ff <= div_quo[27:0];
      end
    end
  end

  // built-in shapes take the nearest lower source point: decimation
  always_comb begin
    logic [10:0] t;
    t = pos_ff[26:16];
    shape_val = 12'h000;
    case (cur_ff.shape)
      MWG_SQUARE:   shape_val = pos_ff[27] ? 12'h801 : 12'h7FF;
      MWG_RAMP:     shape_val = {~pos_ff[27], pos_ff[26:16]};
      MWG_TRIANGLE: begin
        if (pos_ff[27]) begin
          t = ~pos_ff[26:16];
        end
        shape_val = {~t[10], t[9:0], 1'b0};
      end
      default:      shape_val = 12'h000;
    endcase
  end

  // arbitrary shapes: straight line between neighbouring points
  assign diff        = {arb_rd_data[11], arb_rd_data} - {a_ff[11], a_ff};
  assign interp_prod = $signed(diff) * $signed({1'b0, pos_ff[15:8]});
  assign ram_wdata   = (cur_ff.shape == MWG_ARB) ?
                       12'(a_ff + interp_prod[19:8]) : shape_val;
  assign ram_we      = (state_ff == MWG_FILL_W);

  // fill walk over the source at step points per table entry
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      pos_ff      <= 28'h0000000;
      wr_idx_ff   <= 13'h0000;
      a_ff        <= 12'h000;
      arb_addr_ff <= 12'h000;
    end else begin
      case (state_ff)
        MWG_DIV_STEP: begin
          pos_ff    <= 28'h0000000;
          wr_idx_ff <= 13'h0000;
        end
        MWG_FILL_A: arb_addr_ff <= pos_ff[27:16];
        MWG_FILL_B: begin
          a_ff        <= arb_rd_data;
          arb_addr_ff <= pos_ff[27:16] + 12'h001;
        end
        MWG_FILL_W: begin
          pos_ff    <= pos_ff + step_ff;
          wr_idx_ff <= wr_idx_ff + 13'h0001;
        end
        default: ;
      endcase
    end
  end

  // table RAM is private; nothing here writes the arbitrary source
  always_ff @(posedge ref_clk) begin
    if (ram_we) begin
      mod_ram[wr_idx_ff[11:0]] <= ram_wdata;
    end
  end

  // table is trusted only after a full fill
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      tbl_ok_ff <= 1'b0;
    end else if (chg) begin
      tbl_ok_ff <= 1'b0;
    end else if (ram_we && nxt_state == MWG_IDLE) begin
      tbl_ok_ff <= 1'b1;
    end
  end

  // readout side
  logic [2:0]  base_cnt_ff;
  logic [20:0] pre_cnt_ff;
  logic [2:0]  base_last;
  logic        base_tick;
  logic        pend_ff, inflight_ff;
  logic [11:0] rd_addr_ff;
  logic [11:0] ram_q_ff;
  logic        play, issue, wrap;
  logic        fifo_in_ready;
  logic        run_ff, gate_ff;
  logic [15:0] cyc_ff, min_cnt, applied_ff;
  logic [20:0] sample_in;

  assign base_last = (cur_ff.mod_type == MWG_AM) ? 3'(`MWG_BASE_DIV_AM - 1) :
                     3'(`MWG_BASE_DIV_FM - 1);
  assign play      = tbl_ok_ff && (state_ff == MWG_IDLE) && !chg && (!burst_en || run_ff);
  assign base_tick = play && !pend_ff && (base_cnt_ff == base_last);
  assign issue     = pend_ff && play && fifo_in_ready && !inflight_ff;
  assign wrap      = issue && (13'(rd_addr_ff) == p_ff - 13'h0001);

  // point clock: fixed base divide, then prescaler
  // base keeps its pace while a point waits, so a point costs base times S cycles
  always_ff @(posedge ref_clk) begin
    if (!rst_n || !play) begin
      base_cnt_ff <= 3'h0;
      pre_cnt_ff  <= 21'h000000;
      pend_ff     <= 1'b0;
    end else begin
      base_cnt_ff <= (base_cnt_ff == base_last) ? 3'h0 : base_cnt_ff + 3'h1;
      if (base_tick) begin
        pre_cnt_ff <= (pre_cnt_ff == s_ff - 21'h000001) ? 21'h000000 :
                      pre_cnt_ff + 21'h000001;
      end
      if (base_tick && pre_cnt_ff == s_ff - 21'h000001) begin
        pend_ff <= 1'b1;
      end else if (issue) begin
        pend_ff <= 1'b0;
      end
    end
  end

  // no frequency cut-off: every shape is played at any legal rate
  always_ff @(posedge ref_clk) begin
    if (!rst_n || chg) begin
      rd_addr_ff  <= 12'h000;
      inflight_ff <= 1'b0;
      ram_q_ff    <= 12'h000;
    end else begin
      inflight_ff <= issue;
      if (issue) begin
        ram_q_ff   <= mod_ram[rd_addr_ff];
        rd_addr_ff <= wrap ? 12'h000 : rd_addr_ff + 12'h001;
      end
    end
  end

  // AM takes the top eight bits, signed; FM keeps all twelve
  // the AM code never reaches -128, so its peak stays symmetric at 127
  assign sample_in = {1'b0, (ram_q_ff[11:4] == 8'h80) ? 8'h81 : ram_q_ff[11:4], ram_q_ff};

  mwg_skid_fifo #(.W(20)) u_buf (
    .ref_clk   (ref_clk),
    .rst_n     (rst_n),
    .in_valid  (inflight_ff),
    .in_data   (sample_in[19:0]),
    .in_ready  (fifo_in_ready),
    .out_valid (smp_valid),
    .out_data  (smp),
    .out_ready (smp_ready)
  );

  // burst floor rises one per MHz band above 1 MHz
  always_comb begin
    min_cnt = 16'h0001;
    for (int n = 1; n <= `MWG_BAND_TOP; n++) begin
      if (cur_ff.carrier_limited && cur_ff.carrier_hz > 24'(n * `MWG_BAND_HZ)) begin
        min_cnt = 16'(n + 1);
      end
    end
  end

  // burst: cycles counted on table wraps, so it stops on the last point
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      run_ff     <= 1'b0;
      cyc_ff     <= 16'h0000;
      gate_ff    <= 1'b1;
      applied_ff <= 16'h0001;
    end else begin
      applied_ff <= (cur_ff.burst_count < min_cnt) ? min_cnt : cur_ff.burst_count;
      if (!burst_en) begin
        run_ff <= 1'b0;
      end else if (!run_ff && burst_trig && tbl_ok_ff) begin
        run_ff <= 1'b1;
        cyc_ff <= 16'h0000;
      end else if (run_ff && wrap) begin
        if (cyc_ff + 16'h0001 >= applied_ff) begin
          run_ff <= 1'b0;
        end
        cyc_ff <= cyc_ff + 16'h0001;
      end
      gate_ff <= !burst_en || run_ff;
    end
  end

  // diagnostic answer: two beats, prescaler first
  logic       diag_ph_ff;
  logic       diag_v_ff, diag_l_ff;
  logic [31:0] diag_d_ff;
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      diag_ph_ff <= 1'b0;
      diag_v_ff  <= 1'b0;
      diag_l_ff  <= 1'b0;
      diag_d_ff  <= 32'h00000000;
    end else begin
      diag_v_ff <= 1'b0;
      diag_l_ff <= 1'b0;
      if (diag_ph_ff) begin
        diag_ph_ff <= 1'b0;
        diag_v_ff  <= 1'b1;
        diag_l_ff  <= 1'b1;
        diag_d_ff  <= 32'(p_ff);
      end else if (diagnostic_memory_query) begin
        diag_ph_ff <= 1'b1;
        diag_v_ff  <= 1'b1;
        diag_d_ff  <= 32'(s_ff);
      end
    end
  end

  assign arb_rd_addr         = arb_addr_ff;
  assign carrier_gate        = gate_ff;
  assign burst_count_applied = applied_ff;
  assign diag_valid          = diag_v_ff;
  assign diag_last           = diag_l_ff;
  assign diag_data           = diag_d_ff;
  assign busy                = busy_ff;
  assign range_err           = range_err_ff;

  // checks
  chk_change_starts: assert property (@(posedge ref_clk) disable iff (!rst_n)
    chg |=> state_ff == MWG_DIV_S && !tbl_ok_ff) else $error("change did not recompute");
  chk_type_rebuild: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (state_ff == MWG_IDLE && param.mod_type != cur_ff.mod_type) |=> busy_ff)
    else $error("type change left table stale");
  chk_len_limits: assert property (@(posedge ref_clk) disable iff (!rst_n)
    p_ff >= P_MIN && p_ff <= P_MAX && !p_ff[0]) else $error("table length out of range");
  chk_pre_limits: assert property (@(posedge ref_clk) disable iff (!rst_n)
    s_ff >= 21'h000001 && 48'(s_ff) <= S_MAX) else $error("prescaler out of range");
  chk_addr_wrap: assert property (@(posedge ref_clk) disable iff (!rst_n)
    wrap && !chg |=> rd_addr_ff == 12'h000) else $error("read address did not wrap");
  chk_addr_step: assert property (@(posedge ref_clk) disable iff (!rst_n)
    issue && !wrap && !chg |=> rd_addr_ff == $past(rd_addr_ff) + 12'h001)
    else $error("read address did not step");
  chk_ram_private: assert property (@(posedge ref_clk) disable iff (!rst_n)
    ram_we |-> state_ff == MWG_FILL_W ##1 $stable(arb_addr_ff))
    else $error("table written outside fill");
  chk_burst_floor: assert property (@(posedge ref_clk) disable iff (!rst_n)
    ##1 applied_ff >= $past(min_cnt)) else $error("burst count below floor");
  chk_diag_order: assert property (@(posedge ref_clk) disable iff (!rst_n)
    diag_v_ff && !diag_l_ff |=> diag_v_ff && diag_l_ff && diag_d_ff == 32'(p_ff))
    else $error("diagnostic beats out of order");
  chk_base_rate: assert property (@(posedge ref_clk) disable iff (!rst_n)
    base_tick |=> !base_tick) else $error("point clock base too fast");
  chk_freq_range: assert property (@(posedge ref_clk) disable iff (!rst_n)
    state_ff != MWG_IDLE |-> cur_ff.mod_freq_mhz >= 25'(`MWG_FMIN_MHZ))
    else $error("frequency below range");
  chk_am_peak: assert property (@(posedge ref_clk) disable iff (!rst_n)
    inflight_ff |-> sample_in[19:12] != 8'h80) else $error("AM code past its peak");
endmodule : mwg_gen

// ===== rtl/mwg_skid_fifo.sv
// mwg_skid_fifo: two-entry buffer with valid and ready on both sides
// assumes writer only pushes while in_ready is high
`timescale 1ns/1ps
module mwg_skid_fifo #(
  parameter int W = 20
) (
  // clock and reset
  input  wire logic         ref_clk,
  input  wire logic         rst_n,
  // fill side
  input  wire logic         in_valid,
  input  wire logic [W-1:0] in_data,
  output logic              in_ready,
  // drain side
  output logic              out_valid,
  output logic [W-1:0]      out_data,
  input  wire logic         out_ready
);
  logic [W-1:0] mem_ff [2];
  logic         wp_ff;
  logic         rp_ff;
  logic [1:0]   cnt_ff;
  logic         push;
  logic         pop;

  assign push = in_valid && (cnt_ff != 2'h2);
  assign pop  = out_ready && (cnt_ff != 2'h0);

  // storage and pointers; count is honest so full really stalls the writer
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      wp_ff  <= 1'b0;
      rp_ff  <= 1'b0;
      cnt_ff <= 2'h0;
    end else begin
      if (push) begin
        mem_ff[wp_ff] <= in_data;
        wp_ff         <= ~wp_ff;
      end
      if (pop) begin
        rp_ff <= ~rp_ff;
      end
      cnt_ff <= cnt_ff + {1'b0, push} - {1'b0, pop};
    end
  end

  assign in_ready  = (cnt_ff != 2'h2);
  assign out_valid = (cnt_ff != 2'h0);
  assign out_data  = mem_ff[rp_ff];
endmodule : mwg_skid_fifo

// ===== test/mwg_sink.sv
// mwg_sink: far side model, arbitrary source table and sample sink
// assumes the bench drives hold_off to stall the stream
`timescale 1ns/1ps
module mwg_sink
  import mwg_pkg::*;
(
  // clock
  input  wire logic        ref_clk,
  // arbitrary source, read only
  input  wire logic [11:0] arb_rd_addr,
  output logic [11:0]      arb_rd_data,
  // sample stream
  input  mwg_sample_t      smp,
  input  wire logic        smp_valid,
  output logic             smp_ready,
  input  wire logic        hold_off,
  output int               taken
);
  // word depends on address so a wrong address shows
  assign arb_rd_data = arb_rd_addr ^ 12'hA5C;
  // ready drops only when asked, like a busy synthesizer
  assign smp_ready = !hold_off;
  initial taken = 0;
  // count words handed over
  always @(posedge ref_clk) if (smp_valid && smp_ready) taken <= taken + 1;
endmodule : mwg_sink

// ===== test/tb_top.sv
// tb_top: self-checking bench for the modulation generator
// assumes mwg_sink stands at the far side of the sample stream
`timescale 1ns/1ps
module tb_top
  import mwg_pkg::*;
;
  // stimulus, changed at the falling edge
  logic        ref_clk = 0, rst_n = 0, burst_en = 0, burst_trig = 0, query = 0;
  logic        hold_off = 0;
  mwg_param_t  p = '0;
  // observed outputs
  logic [11:0] arb_a, arb_d;
  mwg_sample_t smp;
  logic        sv, sr, gate, dv, dl, busy, rerr;
  logic [15:0] bca;
  logic [31:0] dd;
  int          taken, bad_count = 0, checks_done = 0;

  always #50 ref_clk = ~ref_clk;

  mwg_gen i_mwg_gen (.ref_clk, .rst_n, .param(p), .arb_rd_addr(arb_a), .arb_rd_data(arb_d),
    .burst_en, .burst_trig, .carrier_gate(gate), .burst_count_applied(bca), .smp,
    .smp_valid(sv), .smp_ready(sr), .diagnostic_memory_query(query), .diag_valid(dv),
    .diag_last(dl), .diag_data(dd), .busy, .range_err(rerr));
  mwg_sink i_mwg_sink (.ref_clk, .arb_rd_addr(arb_a), .arb_rd_data(arb_d), .smp,
    .smp_valid(sv), .smp_ready(sr), .hold_off, .taken);

  task automatic report_and_stop(input bit hung);
    if (hung) bad_count++;
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : report_and_stop

  task automatic cmp(input logic [39:0] got, input logic [39:0] exp);
    checks_done++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp

  // a rebuild must start within 20 cycles and end within the bound
  task automatic settle;
    int n;
    n = 0;
    while (busy !== 1'b1 && n < 20) begin @(negedge ref_clk); n++; end
    cmp(busy, 1);
    while (busy !== 1'b0 && n < 20000) begin @(negedge ref_clk); n++; end
    if (n >= 20000) report_and_stop(1);
  endtask : settle

  // query answers prescaler, then point count on the next beat
  task automatic diag(input logic [31:0] s, input logic [31:0] pts);
    query = 1;
    @(negedge ref_clk);
    query = 0;
    cmp({dv, dl, dd}, {2'h2, s});
    @(negedge ref_clk);
    cmp({dv, dl, dd}, {2'h3, pts});
  endtask : diag

  // both kinds at plain and clamped frequencies (mHz)
  task automatic t_calc;
    int f[4] = '{1000000, 100000, 30000000, 5};
    int s[4] = '{4, 6, 1, 62400};
    int n[4] = '{2048, 3570, 2048, 4006};
    for (int i = 0; i < 4; i++) begin
      p.mod_type = mwg_mod_t'(i[0]);
      p.mod_freq_mhz = f[i][24:0];
      settle;
      cmp(rerr, i > 1);
      diag(s[i], n[i]);
    end
    $display("t_calc done");
  endtask : t_calc

  // AM at 1 kHz: one word per 8 cycles; a stall loses nothing
  task automatic t_stream;
    int c;
    mwg_sample_t w;
    p.mod_type = MWG_AM;
    p.mod_freq_mhz = 25'hF4240;
    settle;
    repeat (40) @(negedge ref_clk);
    c = taken;
    repeat (80) @(negedge ref_clk);
    cmp(taken - c, 10);
    cmp(smp.am_code == 8'h7F || smp.am_code == 8'h81, 1);
    cmp(smp.fm_word == 12'h7FF || smp.fm_word == 12'h801, 1);
    hold_off = 1;
    repeat (60) @(negedge ref_clk);
    w = smp;
    c = taken;
    repeat (60) @(negedge ref_clk);
    cmp({sv, smp}, {1'b1, w});
    hold_off = 0;
    @(negedge ref_clk);
    cmp(taken - c, 1);
    $display("t_stream done");
  endtask : t_stream

  // arbitrary shape at 2048 points takes every second source word
  task automatic t_arb;
    p.shape = MWG_ARB;
    settle;
    hold_off = 1;
    repeat (40) @(negedge ref_clk);
    cmp({sv, smp}, {1'b1, 8'hA5, 12'hA5C});
    hold_off = 0;
    @(negedge ref_clk);
    cmp({sv, smp}, {1'b1, 8'hA5, 12'hA5E});
    $display("t_arb done");
  endtask : t_arb

  // burst floor, then one 2048-point pass at 2 cycles a point
  task automatic t_burst;
    int n;
    p.carrier_limited = 1;
    p.carrier_hz = 24'h44AA20;
    p.burst_count = 16'h2;
    settle;
    cmp(bca, 5);
    p.carrier_hz = 24'h7A120;
    p.burst_count = 16'h1;
    p.mod_freq_mhz = 25'h1312D00;
    settle;
    cmp(bca, 1);
    burst_en = 1;
    repeat (4) @(negedge ref_clk);
    cmp(gate, 0);
    burst_trig = 1;
    @(negedge ref_clk);
    burst_trig = 0;
    repeat (2) @(negedge ref_clk);
    cmp(gate, 1);
    n = 0;
    while (gate === 1'b1 && n < 9000) begin
      burst_trig = (n == 999);
      @(negedge ref_clk);
      n++;
    end
    cmp(n >= 4088 && n <= 4112, 1);
    $display("t_burst done");
  endtask : t_burst

  initial begin
    repeat (16) @(negedge ref_clk);
    cmp({sv, busy, gate, arb_a, rerr, bca}, {3'h1, 13'h0, 16'h1});
    rst_n = 1;
    settle;
    t_calc;
    t_stream;
    t_arb;
    t_burst;
    report_and_stop(0);
  end
endmodule : tb_top
